//--- rtl/tgd_pkg.sv
package tgd_pkg;

   // number of byte registers in the table
   localparam int TGD_NREG = 32;

   // byte offsets of the table registers, index order
   localparam logic [7:0] TGD_OFS [TGD_NREG] = '{
      8'hC6, 8'hC7, 8'hC8, 8'hC9, 8'hCA, 8'hCB, 8'hCC, 8'hCD,
      8'hCE, 8'hCF, 8'hD0, 8'hD1, 8'hDC, 8'hDD, 8'hDE, 8'hDF,
      8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'hE6, 8'hE7,
      8'hE8, 8'hE9, 8'hEA, 8'hEB, 8'hEC, 8'hED, 8'hEE, 8'hEF};

   // reset values, index order
   localparam logic [7:0] TGD_RST [TGD_NREG] = '{
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h44,
      8'h02, 8'h04, 8'h06, 8'h08, 8'h10, 8'h19, 8'h1F, 8'h04,
      8'h02, 8'h1F, 8'h04, 8'h02, 8'h08, 8'h10, 8'h18, 8'h53};

   // implemented bits; reserved bits store and read as zero
   localparam logic [7:0] TGD_MASK [TGD_NREG] = '{
      8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
      8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
      8'h1F, 8'h1F, 8'h1F, 8'h0F, 8'h1F, 8'h1F, 8'hFF, 8'h3F,
      8'h1F, 8'hFF, 8'h3F, 8'h1F, 8'h1F, 8'h1F, 8'h1F, 8'hFF};

   // register indices
   localparam int TGD_I_OSC1_COEF = 0;
   localparam int TGD_I_OSC2_COEF = 2;
   localparam int TGD_I_ON_TIME = 4;
   localparam int TGD_I_OFF_TIME = 8;
   localparam int TGD_I_RING = 12;
   localparam int TGD_I_TX_GAIN = 13;
   localparam int TGD_I_RX_GAIN = 14;
   localparam int TGD_I_GAIN_HI = 15;
   localparam int TGD_I_STEP_NR = 16;
   localparam int TGD_I_STEP_RG = 19;
   localparam int TGD_I_SKIP_NR = 22;
   localparam int TGD_I_SKIP_RG = 25;
   localparam int TGD_I_MARK = 28;
   localparam int TGD_I_FINE = 31;

   // extra control and status registers
   localparam logic [7:0] TGD_ADDR_OSC_CTRL = 8'hD2;
   localparam logic [7:0] TGD_ADDR_OSC_STAT = 8'hD3;
   localparam logic [1:0] TGD_OSC_CTRL_RST = 2'h0;

   // field counts and widths
   localparam int TGD_NOSC = 2;
   localparam int TGD_NSET = 3;
   localparam int TGD_STEP_W = 5;
   localparam int TGD_SKIP_W = 8;
   localparam int TGD_MARK_W = 5;
   localparam int TGD_RING_W = 6;
   localparam int TGD_GAIN_W = 12;
   localparam int TGD_NIB_W = 4;

   // cadence tick: 125 us at a 100 ns clock
   localparam int TGD_TICK_NS = 125000;
   localparam int TGD_CLK_NS = 100;
   localparam int TGD_TICK_CYC = (TGD_TICK_NS + TGD_CLK_NS - 1) / TGD_CLK_NS;

endpackage : tgd_pkg

//--- rtl/tgd_cadence_timer.sv
`timescale 1ns/1ps
module tgd_cadence_timer
   import tgd_pkg::*;
#(
   parameter int TW = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic tick,
   input wire logic [TW-1:0] active_time,
   input wire logic [TW-1:0] inactive_time,
   output logic tone_on
);

   // cadence phases
   typedef enum logic [1:0] {ST_IDLE, ST_ACTIVE, ST_INACTIVE, ST_DONE} tgd_phase_t;

   tgd_phase_t state_r; // current phase
   logic [TW-1:0] count_r; // ticks spent in the phase
   logic [TW-1:0] cnt_inc; // count plus one
   logic on_end; // active phase expires on this tick
   logic off_end; // inactive phase expires on this tick

   assign cnt_inc = count_r + {{(TW-1){1'b0}}, 1'b1};
   assign on_end = tick && (active_time != '0) && (cnt_inc >= active_time);
   assign off_end = tick && (cnt_inc >= inactive_time);

   // phase sequencer; a zero time disables that timer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         count_r <= '0;
         tone_on <= 1'b0;
      end else if (!enable) begin
         state_r <= ST_IDLE;
         count_r <= '0;
         tone_on <= 1'b0;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               state_r <= ST_ACTIVE;
               count_r <= '0;
               tone_on <= 1'b1;
            end
            ST_ACTIVE: begin
               // zero active time: timer off, output stays on
               if (on_end && (inactive_time == '0)) begin
                  state_r <= ST_DONE;
                  tone_on <= 1'b0;
               end else if (on_end) begin
                  state_r <= ST_INACTIVE;
                  count_r <= '0;
                  tone_on <= 1'b0;
               end else if (tick && (active_time != '0)) begin
                  count_r <= cnt_inc;
               end
            end
            ST_INACTIVE: begin
               if (off_end || (inactive_time == '0)) begin
                  state_r <= ST_ACTIVE;
                  count_r <= '0;
                  tone_on <= 1'b1;
               end else if (tick) begin
                  count_r <= cnt_inc;
               end
            end
            ST_DONE: begin
               // one burst only; re-arm by dropping enable
               tone_on <= 1'b0;
            end
         endcase
      end
   end

   chk_zero_stays_on: assert property (@(posedge clk) disable iff (!rst_n)
      (enable && tone_on && active_time == '0) |=> tone_on)
      else $error("zero active time did not hold tone on");

   chk_on_to_off: assert property (@(posedge clk) disable iff (!rst_n)
      (enable && state_r == ST_ACTIVE && on_end) |=> !tone_on)
      else $error("active phase did not end on its last tick");

   chk_idle_quiet: assert property (@(posedge clk) disable iff (!rst_n)
      !enable |=> !tone_on)
      else $error("tone on while disabled");

   // inactive phases last thousands of clocks, so watch the phase change itself
   cov_cadence: cover property (@(posedge clk) disable iff (!rst_n)
      state_r == ST_INACTIVE ##1 state_r == ST_ACTIVE);

endmodule : tgd_cadence_timer

//--- rtl/tgd_regs.sv
`timescale 1ns/1ps
// Contract
// - osc2 coefficient 18 bits, lsbs in ring register
// - osc1 coefficient 16 bits, low then high
// - active/inactive times 16 bits, 125 us steps
// - zero time disables that cadence timer
// - 6-bit ring dc offset, 1.484 V steps
// - 12-bit gains, 0x400 unity, shared high nibbles
// - three step sizes, separate ringing set
// - three skip periods, separate ringing set
// - level marks and fine region, 1.484 V units
// - fine register holds loop filter constant
module tgd_regs
   import tgd_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rdata,
   input wire logic ringing_state,
   output logic [15:0] osc1_frequency_coef,
   output logic [17:0] osc2_frequency_coef,
   output logic [TGD_NOSC-1:0] osc_tone_on,
   output logic [TGD_RING_W-1:0] ring_offset_value,
   output logic [TGD_GAIN_W-1:0] tx_gain,
   output logic [TGD_GAIN_W-1:0] rx_gain,
   output logic [TGD_NSET*TGD_STEP_W-1:0] dcdc_step_size,
   output logic [TGD_NSET*TGD_SKIP_W-1:0] dcdc_skip_period,
   output logic [TGD_NSET*TGD_MARK_W-1:0] dcdc_level_mark,
   output logic [3:0] fine_adjust_region,
   output logic [3:0] loop_sense_filter_constant
);

   // table storage, one byte per register
   logic [7:0] reg_r [TGD_NREG];

   // per-register address match
   logic [TGD_NREG-1:0] hit_w;

   // extra control: oscillator enables
   logic [TGD_NOSC-1:0] osc_en_r;

   // decode of the extra registers
   wire ctrl_hit = (addr == TGD_ADDR_OSC_CTRL);
   wire stat_hit = (addr == TGD_ADDR_OSC_STAT);

   // timer outputs, raw from the cadence timers
   logic [TGD_NOSC-1:0] tone_w;

   // shared 125 us tick
   logic [$clog2(TGD_TICK_CYC)-1:0] pre_r;
   logic tick_r;

   // read path
   logic [7:0] tbl_rd;
   wire [7:0] rd_mux;

   // selected dc/dc step and skip sets, registered; level marks straight from registers
   logic [TGD_NSET*TGD_STEP_W-1:0] step_r;
   logic [TGD_NSET*TGD_SKIP_W-1:0] skip_r;
   logic [TGD_NSET*TGD_STEP_W-1:0] step_sel;
   logic [TGD_NSET*TGD_SKIP_W-1:0] skip_sel;
   logic [TGD_NSET*TGD_MARK_W-1:0] mark_w;

   localparam logic [$clog2(TGD_TICK_CYC)-1:0] PRE_LAST =
      ($clog2(TGD_TICK_CYC))'(TGD_TICK_CYC - 1);

   // register cells; write stores only implemented bits
   for (genvar i = 0; i < TGD_NREG; i++) begin : g_reg
      assign hit_w[i] = (addr == TGD_OFS[i]);
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            reg_r[i] <= TGD_RST[i];
         end else if (wr_en && hit_w[i]) begin
            reg_r[i] <= wdata & TGD_MASK[i];
         end
      end
   end

   // enable register write
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         osc_en_r <= TGD_OSC_CTRL_RST;
      end else if (wr_en && ctrl_hit) begin
         osc_en_r <= wdata[TGD_NOSC-1:0];
      end
   end

   // table read mux; addresses are distinct so an or-tree is enough
   always_comb begin
      tbl_rd = 8'h00;
      for (int j = 0; j < TGD_NREG; j++) begin
         tbl_rd = tbl_rd | (hit_w[j] ? reg_r[j] : 8'h00);
      end
   end

   // unmapped addresses read as zero
   assign rd_mux = ctrl_hit ? {{(8-TGD_NOSC){1'b0}}, osc_en_r} :
                   stat_hit ? {{(8-TGD_NOSC){1'b0}}, osc_tone_on} :
                   tbl_rd;

   // read data valid only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata <= 8'h00;
      end else begin
         rdata <= rd_en ? rd_mux : 8'h00;
      end
   end

   // 125 us prescaler shared by both timers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pre_r <= '0;
         tick_r <= 1'b0;
      end else begin
         pre_r <= (pre_r == PRE_LAST) ? '0 : pre_r + 1'b1;
         tick_r <= (pre_r == PRE_LAST);
      end
   end

   // cadence timers, one per oscillator
   for (genvar k = 0; k < TGD_NOSC; k++) begin : g_osc
      tgd_cadence_timer #(
         .TW(16)
      ) u_timer (
         .clk(clk),
         .rst_n(rst_n),
         .enable(osc_en_r[k]),
         .tick(tick_r),
         .active_time({reg_r[TGD_I_ON_TIME+2*k+1], reg_r[TGD_I_ON_TIME+2*k]}),
         .inactive_time({reg_r[TGD_I_OFF_TIME+2*k+1], reg_r[TGD_I_OFF_TIME+2*k]}),
         .tone_on(tone_w[k])
      );
   end

   // ringing set chosen when the line is ringing
   for (genvar s = 0; s < TGD_NSET; s++) begin : g_set
      assign step_sel[s*TGD_STEP_W +: TGD_STEP_W] = ringing_state ?
         reg_r[TGD_I_STEP_RG+s][TGD_STEP_W-1:0] :
         reg_r[TGD_I_STEP_NR+s][TGD_STEP_W-1:0];
      assign skip_sel[s*TGD_SKIP_W +: TGD_SKIP_W] = ringing_state ?
         reg_r[TGD_I_SKIP_RG+s] : reg_r[TGD_I_SKIP_NR+s];
      assign mark_w[s*TGD_MARK_W +: TGD_MARK_W] =
         reg_r[TGD_I_MARK+s][TGD_MARK_W-1:0];
   end

   // registering the selection keeps outputs glitch-free on state change
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         step_r <= '0;
         skip_r <= '0;
         osc_tone_on <= '0;
      end else begin
         step_r <= step_sel;
         skip_r <= skip_sel;
         osc_tone_on <= tone_w;
      end
   end

   // coefficient assembly straight from register bits
   assign osc1_frequency_coef = {reg_r[TGD_I_OSC1_COEF+1], reg_r[TGD_I_OSC1_COEF]};
   assign osc2_frequency_coef = {reg_r[TGD_I_OSC2_COEF+1], reg_r[TGD_I_OSC2_COEF],
                                 reg_r[TGD_I_RING][7:6]};

   // ring dc offset in the low six bits
   assign ring_offset_value = reg_r[TGD_I_RING][TGD_RING_W-1:0];

   // tx nibble low, rx nibble high in the shared register
   assign tx_gain = {reg_r[TGD_I_GAIN_HI][TGD_NIB_W-1:0], reg_r[TGD_I_TX_GAIN]};
   assign rx_gain = {reg_r[TGD_I_GAIN_HI][7:TGD_NIB_W], reg_r[TGD_I_RX_GAIN]};

   // dc/dc tuning outputs
   assign dcdc_step_size = step_r;
   assign dcdc_skip_period = skip_r;
   assign dcdc_level_mark = mark_w;
   assign fine_adjust_region = reg_r[TGD_I_FINE][3:0];
   assign loop_sense_filter_constant = reg_r[TGD_I_FINE][7:4];

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   chk_read_zero_gap: assert property (!rd_en |=> rdata == 8'h00)
      else $error("read data outside the read slot");

   chk_ctrl_readback: assert property (
      wr_en && ctrl_hit ##1 rd_en && ctrl_hit && !wr_en
      |=> rdata[TGD_NOSC-1:0] == $past(wdata[TGD_NOSC-1:0], 2))
      else $error("enable register readback wrong");

   chk_osc1_high: assert property (
      wr_en && addr == TGD_OFS[TGD_I_OSC1_COEF+1]
      |=> osc1_frequency_coef[15:8] == $past(wdata))
      else $error("osc1 high byte not stored");

   chk_osc2_lsbs: assert property (
      wr_en && addr == TGD_OFS[TGD_I_RING]
      |=> osc2_frequency_coef[1:0] == $past(wdata[7:6])
          && ring_offset_value == $past(wdata[TGD_RING_W-1:0]))
      else $error("ring register split wrong");

   chk_osc2_mid: assert property (
      wr_en && addr == TGD_OFS[TGD_I_OSC2_COEF]
      |=> osc2_frequency_coef[9:2] == $past(wdata))
      else $error("osc2 middle byte misplaced");

   chk_gain_nibbles: assert property (
      wr_en && addr == TGD_OFS[TGD_I_GAIN_HI]
      |=> tx_gain[11:8] == $past(wdata[3:0]) && rx_gain[11:8] == $past(wdata[7:4]))
      else $error("gain high nibbles swapped");

   chk_step_ringing: assert property (
      ringing_state && !wr_en ##1 ringing_state
      |=> dcdc_step_size[TGD_STEP_W-1:0] == $past(reg_r[TGD_I_STEP_RG][TGD_STEP_W-1:0]))
      else $error("ringing step set not selected");

   chk_skip_nonring: assert property (
      !ringing_state && !wr_en ##1 !ringing_state
      |=> dcdc_skip_period[TGD_SKIP_W-1:0] == $past(reg_r[TGD_I_SKIP_NR]))
      else $error("non-ringing skip set not selected");

   chk_fine_fields: assert property (
      wr_en && addr == TGD_OFS[TGD_I_FINE]
      |=> fine_adjust_region == $past(wdata[3:0])
          && loop_sense_filter_constant == $past(wdata[7:4]))
      else $error("fine register fields wrong");

   chk_mark_mask: assert property (
      wr_en && addr == TGD_OFS[TGD_I_MARK]
      |=> dcdc_level_mark[TGD_MARK_W-1:0] == $past(wdata[TGD_MARK_W-1:0]))
      else $error("level mark not stored");

   chk_tick_period: assert property (tick_r |=> !tick_r [*8])
      else $error("tick repeated too soon");

   chk_disabled_silent: assert property (!osc_en_r[0] ##1 !osc_en_r[0] |=> !osc_tone_on[0])
      else $error("disabled oscillator is sounding");

   cov_ring_switch: cover property (!ringing_state ##1 ringing_state);
   cov_tone_start: cover property (!osc_tone_on[1] ##1 osc_tone_on[1]);
   cov_read_table: cover property (rd_en && hit_w[TGD_I_FINE]);
   cov_unmapped: cover property (rd_en && hit_w == '0 && !ctrl_hit && !stat_hit);

endmodule : tgd_regs

//--- bench/tgd_regs_tb.sv
`timescale 1ns/1ps
module tgd_regs_tb;
   import tgd_pkg::*;
   logic clk = 1'b0; // 10 MHz system clock
   logic rst_n = 1'b0; // synchronous reset, held for six cycles
   logic [7:0] addr = 8'h00; // register bus address
   logic [7:0] wdata = 8'h00; // register bus write data
   logic wr_en = 1'b0; // one-cycle write strobe
   logic rd_en = 1'b0; // one-cycle read strobe
   logic ringing_state = 1'b0; // selects the ringing step/skip set
   logic [7:0] rdata;
   logic [15:0] osc1_frequency_coef;
   logic [17:0] osc2_frequency_coef;
   logic [TGD_NOSC-1:0] osc_tone_on;
   logic [TGD_RING_W-1:0] ring_offset_value;
   logic [TGD_GAIN_W-1:0] tx_gain;
   logic [TGD_GAIN_W-1:0] rx_gain;
   logic [TGD_NSET*TGD_STEP_W-1:0] dcdc_step_size;
   logic [TGD_NSET*TGD_SKIP_W-1:0] dcdc_skip_period;
   logic [TGD_NSET*TGD_MARK_W-1:0] dcdc_level_mark;
   logic [3:0] fine_adjust_region;
   logic [3:0] loop_sense_filter_constant;
   int num_errors = 0; // mismatches seen
   int num_checks = 0; // comparisons made
   int cyc = 0; // watchdog cycle count
   int cnt; // measured cycles
   int tk = TGD_TICK_CYC; // one cadence tick in clocks
   logic [7:0] rd_val; // last read result
   logic [7:0] pats [2] = '{8'hA5, 8'h5A}; // readback patterns
   logic [7:0] unmapped [5] = '{8'h00, 8'hC5, 8'hD4, 8'hF3, 8'hFF}; // holes in the map

   // free-running clock, 100 ns period
   always #50 clk = ~clk;

   tgd_regs uut (
      .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rdata(rdata), .ringing_state(ringing_state),
      .osc1_frequency_coef(osc1_frequency_coef), .osc2_frequency_coef(osc2_frequency_coef),
      .osc_tone_on(osc_tone_on), .ring_offset_value(ring_offset_value),
      .tx_gain(tx_gain), .rx_gain(rx_gain), .dcdc_step_size(dcdc_step_size),
      .dcdc_skip_period(dcdc_skip_period), .dcdc_level_mark(dcdc_level_mark),
      .fine_adjust_region(fine_adjust_region),
      .loop_sense_filter_constant(loop_sense_filter_constant)
   );

   // watchdog: the whole run needs about 16000 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         num_errors = num_errors + 1;
         stop_test();
      end
   end

   // verdict and end of run
   task stop_test;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test

   // compare any value up to 32 bits, four-state exact
   task check(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // one-cycle write strobe
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask : wr

   // one-cycle read strobe; data is looked at only in the following cycle
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask : rd

   // read and compare
   task rdc(input logic [7:0] a, input logic [7:0] e, input string n);
      rd(a, rd_val);
      check(n, e, rd_val);
   endtask : rdc

   // let registered outputs follow the last write or select change
   task settle;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask : settle

   // wait for a tone bit to reach a level, bounded
   task wait_lvl(input int k, input logic v, output int c);
      c = 0;
      while (osc_tone_on[k] !== v && c < 10000) begin
         @(negedge clk);
         c++;
      end
   endtask : wait_lvl

   // count cycles with a tone bit high
   task count_on(input int k, input int n, output int c);
      c = 0;
      repeat (n) begin
         @(negedge clk);
         if (osc_tone_on[k] === 1'b1) c++;
      end
   endtask : count_on

   // main sequence
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      settle();
      // defaults straight after reset
      for (int i = 0; i < TGD_NREG; i++) rdc(TGD_OFS[i], TGD_RST[i], "reset value");
      check("tx_gain", 12'h400, tx_gain);
      check("rx_gain", 12'h400, rx_gain);
      check("step l0", {5'h06, 5'h04, 5'h02}, dcdc_step_size);
      check("skip l0", {8'h02, 8'h04, 8'h1F}, dcdc_skip_period);
      check("marks", {5'h18, 5'h10, 5'h08}, dcdc_level_mark);
      check("fine region", 4'h3, fine_adjust_region);
      check("filter", 4'h5, loop_sense_filter_constant);
      @(posedge clk);
      ringing_state <= 1'b1;
      settle();
      check("step l1", {5'h19, 5'h10, 5'h08}, dcdc_step_size);
      $display("test defaults done");

      // every table register back to back, reserved bits read zero
      foreach (pats[p]) begin
         for (int i = 0; i < TGD_NREG; i++) wr(TGD_OFS[i], pats[p] ^ 8'(i));
         for (int i = 0; i < TGD_NREG; i++)
            rdc(TGD_OFS[i], (pats[p] ^ 8'(i)) & TGD_MASK[i], "readback");
      end
      // holes in the map keep nothing and read zero
      foreach (unmapped[u]) begin
         wr(unmapped[u], 8'hFF);
         rdc(unmapped[u], 8'h00, "unmapped");
      end
      rd(8'hC7, rd_val);
      @(negedge clk);
      check("rdata after read", 8'h00, rdata);
      $display("test access done");

      // coefficient, offset and gain packing
      wr(8'hC6, 8'h34);
      wr(8'hC7, 8'h12);
      wr(8'hC8, 8'hAB);
      wr(8'hC9, 8'hCD);
      wr(8'hDC, 8'hC5);
      wr(8'hDD, 8'h00);
      wr(8'hDE, 8'hFF);
      wr(8'hDF, 8'h47);
      settle();
      check("osc1 coef", 16'h1234, osc1_frequency_coef);
      check("osc2 coef", {8'hCD, 8'hAB, 2'b11}, osc2_frequency_coef);
      check("ring offset", 6'h05, ring_offset_value);
      check("tx_gain", {4'h7, 8'h00}, tx_gain);
      check("rx_gain", {4'h4, 8'hFF}, rx_gain);
      // recommended tuning set, both region states
      for (int i = 0; i < 6; i++) wr(8'(8'hE0 + i), (i < 3) ? 8'h02 : 8'h08);
      for (int i = 0; i < 6; i++) wr(8'(8'hE6 + i), 8'h06);
      wr(8'hEC, 8'h01);
      wr(8'hED, 8'h02);
      wr(8'hEE, 8'h02);
      wr(8'hEF, 8'h60);
      settle();
      check("step l1", {5'h08, 5'h08, 5'h08}, dcdc_step_size);
      check("marks", {5'h02, 5'h02, 5'h01}, dcdc_level_mark);
      check("fine region", 4'h0, fine_adjust_region);
      check("filter", 4'h6, loop_sense_filter_constant);
      @(posedge clk);
      ringing_state <= 1'b0;
      settle();
      check("step l0", {5'h02, 5'h02, 5'h02}, dcdc_step_size);
      check("skip l0", {8'h06, 8'h06, 8'h06}, dcdc_skip_period);
      $display("test packing done");

      // cadence: two ticks on, one tick off
      wr(8'hCA, 8'h02);
      wr(8'hCB, 8'h00);
      wr(8'hCE, 8'h01);
      wr(8'hCF, 8'h00);
      wr(8'hCC, 8'h00);
      wr(8'hCD, 8'h00);
      wr(8'hD2, 8'h01);
      wait_lvl(0, 1'b1, cnt);
      check("tone start", 1, cnt < 20);
      wait_lvl(0, 1'b0, cnt);
      // first active phase starts at a free prescaler phase, so it runs short
      check("first active time", 1, cnt >= tk - 2 && cnt <= 2 * tk + 2);
      wait_lvl(0, 1'b1, cnt);
      check("inactive time", 1, cnt >= tk - 2 && cnt <= 2 * tk + 2);
      // later phases are tick aligned: two full ticks
      wait_lvl(0, 1'b0, cnt);
      check("active time", 1, cnt >= 2 * tk - 2 && cnt <= 2 * tk + 2);
      // zero inactive time: one burst, then silence
      wr(8'hD2, 8'h00);
      wr(8'hCE, 8'h00);
      wr(8'hD2, 8'h01);
      wait_lvl(0, 1'b1, cnt);
      wait_lvl(0, 1'b0, cnt);
      count_on(0, 4000, cnt);
      check("single burst", 0, cnt);
      // zero active time: steady tone on the second oscillator
      wr(8'hD2, 8'h02);
      settle();
      count_on(1, 3000, cnt);
      check("steady tone", 3000, cnt);
      rdc(TGD_ADDR_OSC_STAT, 8'h02, "tone status");
      $display("test cadence done");
      stop_test();
   end
endmodule : tgd_regs_tb
